// >>> rtl/dtg_pkg.sv
// shared types, pin codes and timing counts for the ddr2 command timing guard
package dtg_pkg;

  typedef enum logic [3:0] {
    DTG_NOP = 4'h0,
    DTG_MRS = 4'h1,
    DTG_REF = 4'h2,
    DTG_ACT = 4'h3,
    DTG_RD  = 4'h4,
    DTG_WR  = 4'h5,
    DTG_PRE = 4'h6,
    DTG_PDE = 4'h7,
    DTG_SRE = 4'h8,
    DTG_PDX = 4'h9,
    DTG_SRX = 4'ha
  } dtg_op_type;

  // gray coded along active -> power-down -> self-refresh
  typedef enum logic [1:0] {
    DTG_PW_ACTIVE = 2'h0,
    DTG_PW_DOWN   = 2'h1,
    DTG_PW_SELF   = 2'h3
  } dtg_pwr_type;

  typedef struct packed {
    dtg_op_type  op;
    logic [1:0]  ba;
    logic [12:0] addr;
  } dtg_req_type;

  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [12:0] addr;
  } dtg_pins_type;

  localparam int AUTO_PRE_BIT = 10;
  localparam int EXIT_MODE_BIT = 12;
  localparam logic [1:0] MODE_REG_BANK = 2'h0;
  localparam int NUM_BANKS = 4;
  localparam int CNT_W = 8;

  // {ras_n, cas_n, we_n} with cs_n low
  localparam logic [2:0] CODE_MRS = 3'h0;
  localparam logic [2:0] CODE_REF = 3'h1;
  localparam logic [2:0] CODE_PRE = 3'h2;
  localparam logic [2:0] CODE_ACT = 3'h3;
  localparam logic [2:0] CODE_WR = 3'h4;
  localparam logic [2:0] CODE_RD = 3'h5;
  localparam logic [2:0] CODE_NOP = 3'h7;

  localparam dtg_pins_type PINS_RESET = '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1,
                                          cas_n: 1'b1, we_n: 1'b1, ba: 2'h0, addr: 13'h0000};

  localparam real CLK_PERIOD_NS = 20.0;
  localparam real RRD_1K_NS = 7.5;
  localparam real RRD_2K_NS = 10.0;
  localparam real FAW_1K_NS = 37.5;
  localparam real FAW_2K_NS = 50.0;
  localparam real WR_NS = 15.0;
  localparam real RP_NS = 15.0;
  localparam real WTR_FAST_NS = 7.5;
  localparam real WTR_400_NS = 10.0;
  localparam real RTP_NS = 7.5;
  localparam real RFC_NS = 75.0;
  localparam real XSNR_EXTRA_NS = 10.0;

  // least times round up, never below one cycle
  function automatic int ns_to_cyc(input real ns);
    int c;
    c = int'($ceil(ns / CLK_PERIOD_NS));
    return (c < 1) ? 1 : c;
  endfunction

  localparam int MRD_CYC = 2;
  localparam int CCD_CYC = 2;
  localparam int XSRD_CYC = 200;
  localparam int XP_CYC = 2;
  localparam int XARD_CYC = 2;
  localparam int XARDS_BASE_CYC = 6;
  localparam int RRD_1K_CYC = ns_to_cyc(RRD_1K_NS);
  localparam int RRD_2K_CYC = ns_to_cyc(RRD_2K_NS);
  localparam int FAW_1K_CYC = ns_to_cyc(FAW_1K_NS);
  localparam int FAW_2K_CYC = ns_to_cyc(FAW_2K_NS);
  localparam int WR_CYC = ns_to_cyc(WR_NS);
  localparam int RP_CYC = ns_to_cyc(RP_NS);
  localparam int DAL_CYC = WR_CYC + RP_CYC;
  localparam int WTR_FAST_CYC = ns_to_cyc(WTR_FAST_NS);
  localparam int WTR_400_CYC = ns_to_cyc(WTR_400_NS);
  localparam int RTP_CYC = ns_to_cyc(RTP_NS);
  localparam int RFC_CYC = ns_to_cyc(RFC_NS);
  localparam int XSNR_CYC = ns_to_cyc(RFC_NS + XSNR_EXTRA_NS);

  function automatic logic [2:0] pin_code(input dtg_pins_type p);
    return {p.ras_n, p.cas_n, p.we_n};
  endfunction

  function automatic logic pin_is(input dtg_pins_type p, input logic [2:0] code);
    return !p.cs_n && (pin_code(p) == code);
  endfunction

  function automatic logic pin_any(input dtg_pins_type p);
    return !p.cs_n && (pin_code(p) != CODE_NOP);
  endfunction

endpackage

// >>> rtl/dtg_gap_counter.sv
// down-counter that blocks a command class until its gap has elapsed
module dtg_gap_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] value_i,
  output logic                  idle_o
);

  logic [WIDTH-1:0] count_q;

  // a load never shortens a wait already running
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count_q <= '0;
    end else if (load_i && (value_i > count_q)) begin
      count_q <= value_i;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign idle_o = (count_q == '0);

endmodule

// >>> rtl/dtg_guard.sv
// ddr2 command issuer that spaces commands to honour device timing
// Overview of operation
// (R1) two cycles after mode register set
// (R2) space activates by activate gap
// (R3) at most four activates per window
// (R4) column commands at least two cycles apart
// (R5) write recovery before precharge; autoprecharge delay
// (R6) read waits write-to-read gap after write
// (R7) precharge waits read-to-precharge gap
// (R8) self-refresh exit: refresh time plus 10ns
// (R9) self-refresh exit: 200 cycles before read
// (R10) power-down exit: two cycles before non-read
// (R11) fast active exit: two cycles before read
// (R12) write strobe aligned to its clock edge
// (R13) refresh cycle time is 75ns
// (R14) mode bit 12 picks fast/slow exit
// (R15) ns figures rounded up into counters
module dtg_guard #(
  parameter int WRITE_LATENCY = 2,
  parameter int BURST_LENGTH = 4,
  parameter int ADDITIVE_LATENCY = 0,
  parameter bit PAGE_2KB = 1'b0,
  parameter bit GRADE_400 = 1'b1
) (
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                req_valid_i,
  input  wire dtg_pkg::dtg_req_type req_i,
  output logic                     ack_o,
  output dtg_pkg::dtg_pins_type    pins_o,
  output logic                     wstrobe_o,
  output logic                     fast_exit_o
);

  localparam int HB = BURST_LENGTH / 2;
  localparam int W = dtg_pkg::CNT_W;
  localparam int NB = dtg_pkg::NUM_BANKS;
  localparam int RRD = PAGE_2KB ? dtg_pkg::RRD_2K_CYC : dtg_pkg::RRD_1K_CYC;
  localparam int FAW = PAGE_2KB ? dtg_pkg::FAW_2K_CYC : dtg_pkg::FAW_1K_CYC;
  localparam int WTR = GRADE_400 ? dtg_pkg::WTR_400_CYC : dtg_pkg::WTR_FAST_CYC;
  localparam int RTP_EFF = (dtg_pkg::RTP_CYC > 2) ? dtg_pkg::RTP_CYC : 2;
  localparam int WR_TO_PRE = WRITE_LATENCY + HB + dtg_pkg::WR_CYC;
  localparam int WR_TO_RD = WRITE_LATENCY + HB + WTR;
  localparam int WRA_TO_ACT = WRITE_LATENCY + HB + dtg_pkg::DAL_CYC;
  localparam int RD_TO_PRE = ADDITIVE_LATENCY + HB - 2 + RTP_EFF;
  localparam int RDA_TO_ACT = RD_TO_PRE + dtg_pkg::RP_CYC;
  localparam int XARDS = dtg_pkg::XARDS_BASE_CYC - ADDITIVE_LATENCY;
  localparam int PIPE = WRITE_LATENCY - 1 + HB;

  if (WRITE_LATENCY < 2 || WRITE_LATENCY > 8 || (BURST_LENGTH != 4 && BURST_LENGTH != 8) ||
      ADDITIVE_LATENCY < 0 || ADDITIVE_LATENCY > 4 || WRA_TO_ACT > 255) begin : g_bad
    $error("dtg_guard: unsupported latency or burst setting");
  end

  // counters load n-1 so the next command may land n cycles later
  function automatic logic [W-1:0] gap(input int n);
    return W'(n - 1);
  endfunction

  dtg_pkg::dtg_pwr_type pwr_q;
  dtg_pkg::dtg_pins_type pins_q;
  logic ack_q;
  logic fast_exit_q;
  logic pd_active_q;
  logic [NB-1:0] open_q;
  logic [PIPE-1:0] wpipe_q;
  logic wstrobe_q;

  logic issue;
  logic allowed;
  logic auto_pre;
  dtg_pkg::dtg_op_type op;
  logic all_idle, nonrd_idle, rd_idle, rrd_idle, col_idle;
  logic [3:0] faw_idle;
  logic [3:0] faw_pick;
  logic [NB-1:0] pre_idle, act_idle;
  logic all_load, nonrd_load, rd_load;
  logic [W-1:0] all_val, nonrd_val, rd_val;

  assign op = req_i.op;
  assign auto_pre = req_i.addr[dtg_pkg::AUTO_PRE_BIT];

  always_comb begin
    faw_pick = 4'h0;
    for (int i = 3; i >= 0; i--) begin
      if (faw_idle[i]) begin
        faw_pick = 4'h0;
        faw_pick[i] = 1'b1;
      end
    end
  end

  always_comb begin
    logic active_ok;
    logic pre_ok;
    active_ok = (pwr_q == dtg_pkg::DTG_PW_ACTIVE) && all_idle;
    pre_ok = auto_pre ? (&pre_idle) : pre_idle[req_i.ba];
    case (op)
      dtg_pkg::DTG_NOP: allowed = 1'b1;
      dtg_pkg::DTG_MRS, dtg_pkg::DTG_REF, dtg_pkg::DTG_SRE:
        allowed = active_ok && nonrd_idle && (open_q == '0);
      dtg_pkg::DTG_ACT:
        allowed = active_ok && nonrd_idle && !open_q[req_i.ba] && act_idle[req_i.ba] &&
                  rrd_idle && (|faw_idle); // R2 R3
      dtg_pkg::DTG_RD:
        allowed = active_ok && rd_idle && col_idle && open_q[req_i.ba]; // R4 R6 R9 R11
      dtg_pkg::DTG_WR:
        allowed = active_ok && nonrd_idle && col_idle && open_q[req_i.ba]; // R4 R8 R10
      dtg_pkg::DTG_PRE: allowed = active_ok && nonrd_idle && pre_ok; // R5 R7
      dtg_pkg::DTG_PDE: allowed = active_ok && nonrd_idle;
      dtg_pkg::DTG_PDX: allowed = (pwr_q == dtg_pkg::DTG_PW_DOWN);
      dtg_pkg::DTG_SRX: allowed = (pwr_q == dtg_pkg::DTG_PW_SELF);
      default: allowed = 1'b0;
    endcase
  end

  // the ack cycle still shows the old request, so it is never taken twice
  assign issue = req_valid_i && !ack_q && allowed && (op != dtg_pkg::DTG_NOP);

  always_comb begin
    all_load = issue && (op == dtg_pkg::DTG_MRS || op == dtg_pkg::DTG_REF);
    all_val = (op == dtg_pkg::DTG_MRS) ? gap(dtg_pkg::MRD_CYC) : gap(dtg_pkg::RFC_CYC); // R1 R13
    nonrd_load = issue && (op == dtg_pkg::DTG_SRX || op == dtg_pkg::DTG_PDX);
    nonrd_val = (op == dtg_pkg::DTG_SRX) ? gap(dtg_pkg::XSNR_CYC) : gap(dtg_pkg::XP_CYC); // R8 R10
    rd_load = issue && (op == dtg_pkg::DTG_SRX || op == dtg_pkg::DTG_WR ||
                        (op == dtg_pkg::DTG_PDX && pd_active_q));
    case (op)
      dtg_pkg::DTG_SRX: rd_val = gap(dtg_pkg::XSRD_CYC); // R9
      dtg_pkg::DTG_WR: rd_val = gap(WR_TO_RD); // R6
      default: rd_val = fast_exit_q ? gap(dtg_pkg::XARD_CYC) : gap(XARDS); // R11 R14
    endcase
  end

  dtg_gap_counter #(.WIDTH(W)) u_all (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .load_i(all_load), .value_i(all_val), .idle_o(all_idle));
  dtg_gap_counter #(.WIDTH(W)) u_nonrd (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .load_i(nonrd_load), .value_i(nonrd_val), .idle_o(nonrd_idle));
  dtg_gap_counter #(.WIDTH(W)) u_rd (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .load_i(rd_load), .value_i(rd_val), .idle_o(rd_idle));
  dtg_gap_counter #(.WIDTH(W)) u_rrd (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .load_i(issue && op == dtg_pkg::DTG_ACT), .value_i(gap(RRD)), .idle_o(rrd_idle)); // R2 R15
  dtg_gap_counter #(.WIDTH(W)) u_col (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .load_i(issue && (op == dtg_pkg::DTG_RD || op == dtg_pkg::DTG_WR)),
    .value_i(gap(dtg_pkg::CCD_CYC)), .idle_o(col_idle)); // R4

  // each slot holds one activate for the window; a fifth needs a free slot
  for (genvar s = 0; s < 4; s++) begin : g_faw
    dtg_gap_counter #(.WIDTH(W)) u_slot (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .load_i(issue && op == dtg_pkg::DTG_ACT && faw_pick[s]),
      .value_i(gap(FAW)), .idle_o(faw_idle[s])); // R3
  end

  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic hit;
    logic pre_load, act_load;
    logic [W-1:0] pre_val, act_val;
    assign hit = (req_i.ba == 2'(b));
    assign pre_load = issue && hit && (op == dtg_pkg::DTG_RD || op == dtg_pkg::DTG_WR);
    assign pre_val = (op == dtg_pkg::DTG_WR) ? gap(WR_TO_PRE) : gap(RD_TO_PRE); // R5 R7
    assign act_load = issue && (hit || auto_pre) && (op == dtg_pkg::DTG_PRE ||
                      ((op == dtg_pkg::DTG_RD || op == dtg_pkg::DTG_WR) && hit && auto_pre));
    always_comb begin
      case (op)
        dtg_pkg::DTG_WR: act_val = gap(WRA_TO_ACT); // R5
        dtg_pkg::DTG_RD: act_val = gap(RDA_TO_ACT);
        default: act_val = gap(dtg_pkg::RP_CYC);
      endcase
    end
    dtg_gap_counter #(.WIDTH(W)) u_pre (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .load_i(pre_load), .value_i(pre_val), .idle_o(pre_idle[b]));
    dtg_gap_counter #(.WIDTH(W)) u_act (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .load_i(act_load), .value_i(act_val), .idle_o(act_idle[b]));

    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        open_q[b] <= 1'b0;
      end else if (issue && op == dtg_pkg::DTG_ACT && hit) begin
        open_q[b] <= 1'b1;
      end else if (issue && (hit || auto_pre) && op == dtg_pkg::DTG_PRE) begin
        open_q[b] <= 1'b0;
      end else if (issue && hit && auto_pre &&
                   (op == dtg_pkg::DTG_RD || op == dtg_pkg::DTG_WR)) begin
        open_q[b] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pwr_q <= dtg_pkg::DTG_PW_ACTIVE;
      pd_active_q <= 1'b0;
    end else if (issue) begin
      case (op)
        dtg_pkg::DTG_PDE: begin
          pwr_q <= dtg_pkg::DTG_PW_DOWN;
          pd_active_q <= (open_q != '0);
        end
        dtg_pkg::DTG_SRE: pwr_q <= dtg_pkg::DTG_PW_SELF;
        dtg_pkg::DTG_PDX, dtg_pkg::DTG_SRX: pwr_q <= dtg_pkg::DTG_PW_ACTIVE;
        default: pwr_q <= pwr_q;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fast_exit_q <= 1'b0;
    end else if (issue && op == dtg_pkg::DTG_MRS && req_i.ba == dtg_pkg::MODE_REG_BANK) begin
      fast_exit_q <= !req_i.addr[dtg_pkg::EXIT_MODE_BIT]; // R14
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pins_q <= dtg_pkg::PINS_RESET;
      ack_q <= 1'b0;
    end else begin
      ack_q <= issue;
      pins_q.cs_n <= 1'b1;
      {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= dtg_pkg::CODE_NOP;
      if (issue) begin
        pins_q.ba <= req_i.ba;
        pins_q.addr <= req_i.addr;
        pins_q.cs_n <= 1'b0;
        case (op)
          dtg_pkg::DTG_MRS: {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= dtg_pkg::CODE_MRS;
          dtg_pkg::DTG_REF: {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= dtg_pkg::CODE_REF;
          dtg_pkg::DTG_ACT: {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= dtg_pkg::CODE_ACT;
          dtg_pkg::DTG_RD: {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= dtg_pkg::CODE_RD;
          dtg_pkg::DTG_WR: {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= dtg_pkg::CODE_WR;
          dtg_pkg::DTG_PRE: {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= dtg_pkg::CODE_PRE;
          dtg_pkg::DTG_SRE: begin
            {pins_q.ras_n, pins_q.cas_n, pins_q.we_n} <= dtg_pkg::CODE_REF;
            pins_q.cke <= 1'b0;
          end
          dtg_pkg::DTG_PDE: pins_q.cke <= 1'b0;
          default: pins_q.cke <= 1'b1;
        endcase
      end
    end
  end

  // strobe enable leaves a flop on the same edge as the command pins, so no
  // skew is added here; board routing must hold the quarter-period window
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wpipe_q <= '0;
      wstrobe_q <= 1'b0;
    end else begin
      wpipe_q <= {wpipe_q[PIPE-2:0], issue && op == dtg_pkg::DTG_WR};
      wstrobe_q <= |wpipe_q[WRITE_LATENCY-1 +: HB]; // R12
    end
  end

  assign ack_o = ack_q;
  assign pins_o = pins_q;
  assign wstrobe_o = wstrobe_q;
  assign fast_exit_o = fast_exit_q;

  // helper ages for the checks below
  logic [W-1:0] act_age_q, srx_age_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      act_age_q <= '1;
      srx_age_q <= '1;
    end else begin
      act_age_q <= dtg_pkg::pin_is(pins_q, dtg_pkg::CODE_ACT) ? W'(1) :
                   ((act_age_q == '1) ? act_age_q : act_age_q + 1'b1);
      srx_age_q <= (issue && op == dtg_pkg::DTG_SRX) ? '0 :
                   ((srx_age_q == '1) ? srx_age_q : srx_age_q + 1'b1);
    end
  end

  localparam int WL_I = WRITE_LATENCY;
  localparam int XSNR_I = dtg_pkg::XSNR_CYC;
  localparam int XSRD_I = dtg_pkg::XSRD_CYC;
  logic p_rd, p_nonrd;
  assign p_rd = dtg_pkg::pin_is(pins_q, dtg_pkg::CODE_RD);
  assign p_nonrd = dtg_pkg::pin_any(pins_q) && !p_rd;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_idle2;
    !dtg_pkg::pin_any(pins_q) ##1 1'b1;
  endsequence
  sequence s_burst_start;
    ##WL_I wstrobe_q ##1 wstrobe_q;
  endsequence

  property p_mode_set;
    dtg_pkg::pin_is(pins_q, dtg_pkg::CODE_MRS) |=> s_idle2;
  endproperty
  a_mode_set: assert property (p_mode_set) else $error("command too soon after mode set"); // R1

  property p_act_gap;
    dtg_pkg::pin_is(pins_q, dtg_pkg::CODE_ACT) |-> act_age_q >= W'(RRD);
  endproperty
  a_act_gap: assert property (p_act_gap) else $error("activates too close"); // R2

  property p_faw_slots;
    (issue && op == dtg_pkg::DTG_ACT) |-> $onehot(faw_pick) && (|(faw_pick & faw_idle));
  endproperty
  a_faw_slots: assert property (p_faw_slots) else $error("activate without free window slot"); // R3

  property p_col_gap;
    (p_rd || dtg_pkg::pin_is(pins_q, dtg_pkg::CODE_WR)) |=>
      !(p_rd || dtg_pkg::pin_is(pins_q, dtg_pkg::CODE_WR));
  endproperty
  a_col_gap: assert property (p_col_gap) else $error("column commands too close"); // R4

  property p_srx_nonread;
    p_nonrd |-> srx_age_q >= W'(XSNR_I);
  endproperty
  a_srx_nonread: assert property (p_srx_nonread) else $error("non-read too soon after exit"); // R8

  property p_srx_read;
    p_rd |-> srx_age_q >= W'(XSRD_I);
  endproperty
  a_srx_read: assert property (p_srx_read) else $error("read too soon after exit"); // R9

  property p_pd_exit;
    $rose(pins_q.cke) |=> !dtg_pkg::pin_any(pins_q);
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("command right after power-down exit"); // R10

  property p_exit_mode;
    (dtg_pkg::pin_is(pins_q, dtg_pkg::CODE_MRS) && pins_q.ba == dtg_pkg::MODE_REG_BANK) |->
      fast_exit_q == !pins_q.addr[dtg_pkg::EXIT_MODE_BIT];
  endproperty
  a_exit_mode: assert property (p_exit_mode) else $error("exit mode not taken from bit 12"); // R14

  property p_wr_strobe;
    dtg_pkg::pin_is(pins_q, dtg_pkg::CODE_WR) |-> s_burst_start;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe misplaced"); // R12

endmodule

// >>> verif/dtg_mem_model.sv
// behavioural ddr2 device that flags the command spacing the controller breaks, except refresh and precharge-to-activate times
module dtg_mem_model #(
  parameter int WL = 2,
  parameter int BL = 4,
  parameter int AL = 0
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire dtg_pkg::dtg_pins_type pins_i,
  input wire logic wstrobe_i,
  output logic [15:0] err_count_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ns figures at a 20ns clock, rounded up to whole cycles
  localparam int MODE_GAP = 2;
  localparam int ACT_GAP = 1;
  localparam int FOUR_WIN = 2;
  localparam int COL_GAP = 2;
  localparam int WREC = 1;
  localparam int PRE_T = 1;
  localparam int WTR = 1;
  localparam int SR_NONRD = 5;
  localparam int SR_RD = 200;
  localparam int PD_NONRD = 2;
  localparam int APD_FAST = 2;
  localparam int APD_SLOW = 6 - AL;
  // earliest legal cycle: 0 any, 1 column, 2 read, 3 non-read, 4 activate
  int g [5];
  int bpre [4];
  int bact [4];
  int t_act [4];
  int cyc, ws_a, ws_b, b;
  logic [3:0] open_q;
  logic fast_q, self_q, cke_q, is_rd;
  logic [15:0] errs = 16'h0000;
  logic [2:0] code;
  logic is_cmd;
  assign err_count_o = errs;
  assign code = {pins_i.ras_n, pins_i.cas_n, pins_i.we_n};
  assign is_cmd = pins_i.cke && !pins_i.cs_n && (code != 3'h7);

  function automatic int mx(input int x, input int y);
    return (x > y) ? x : y;
  endfunction

  task automatic chk(input bit ok, input string what);
    if (!ok) begin
      errs = errs + 16'h0001;
      $display("mismatch %s expected 1 seen 0 at device cycle %0d", what, cyc);
    end
  endtask

  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      cyc = 0;
      foreach (g[i]) g[i] = 0;
      foreach (bpre[i]) bpre[i] = 0;
      foreach (bact[i]) bact[i] = 0;
      t_act = '{-99, -99, -99, -99};
      ws_a = -99;
      ws_b = -99;
      open_q = 4'h0;
      fast_q = 1'b0;
      self_q = 1'b0;
      cke_q = 1'b1;
    end else begin
      cyc = cyc + 1;
      if (pins_i.cke && !cke_q) begin
        if (self_q) begin
          g[2] = mx(g[2], cyc + SR_RD);
          g[3] = mx(g[3], cyc + SR_NONRD);
        end else begin
          g[3] = mx(g[3], cyc + PD_NONRD);
          if (open_q != 4'h0) g[2] = mx(g[2], cyc + (fast_q ? APD_FAST : APD_SLOW));
        end
      end
      if (!pins_i.cke && cke_q) self_q = !pins_i.cs_n && (code == dtg_pkg::CODE_REF);
      cke_q = pins_i.cke;
      // strobe window must sit exactly on the write latency edge
      chk(wstrobe_i === ((cyc >= ws_a && cyc < ws_a + BL / 2) ||
                         (cyc >= ws_b && cyc < ws_b + BL / 2)), "write strobe");
      if (is_cmd) begin
        b = int'(pins_i.ba);
        is_rd = (code == dtg_pkg::CODE_RD);
        chk(cyc >= g[0], "mode set spacing");
        chk(cyc >= g[is_rd ? 2 : 3], "exit or write to read gap");
        case (code)
          dtg_pkg::CODE_MRS: begin
            g[0] = cyc + MODE_GAP;
            if (pins_i.ba == 2'h0) fast_q = !pins_i.addr[12];
          end
          dtg_pkg::CODE_ACT: begin
            chk(cyc >= g[4], "activate gap");
            chk(cyc >= t_act[3] + FOUR_WIN, "four activate window");
            chk(cyc >= bact[b], "autoprecharge write delay");
            t_act = '{cyc, t_act[0], t_act[1], t_act[2]};
            g[4] = cyc + ACT_GAP;
            open_q[b] = 1'b1;
          end
          dtg_pkg::CODE_RD, dtg_pkg::CODE_WR: begin
            chk(cyc >= g[1], "column gap");
            g[1] = cyc + COL_GAP;
            if (!is_rd) begin
              ws_a = ws_b;
              ws_b = cyc + WL;
              g[2] = mx(g[2], cyc + WL + BL / 2 + WTR);
              bpre[b] = mx(bpre[b], cyc + WL + BL / 2 + WREC);
              bact[b] = cyc + WL + BL / 2 + WREC + PRE_T;
            end else begin
              bpre[b] = mx(bpre[b], cyc + AL + BL / 2);
            end
            if (pins_i.addr[10]) open_q[b] = 1'b0;
          end
          dtg_pkg::CODE_PRE: begin
            for (int i = 0; i < 4; i++) begin
              if (pins_i.addr[10] || b == i) begin
                chk(cyc >= bpre[i], "precharge gap");
                open_q[i] = 1'b0;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule

// >>> verif/dtg_guard_tb.sv
// self-checking bench for the ddr2 command timing guard
module dtg_guard_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    dtg_pkg::dtg_op_type op;
    logic [1:0] ba;
    logic [12:0] a;
    logic [3:0] exp;
    logic fx;
    logic [7:0] gap;
  } dtg_row_type;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  dtg_pkg::dtg_req_type req_i = '0;
  logic ack_o, wstrobe_o, fast_exit_o;
  dtg_pkg::dtg_pins_type pins_o;
  logic [15:0] err_count;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int last_ack = 0;
  dtg_row_type rows [32];

  dtg_guard dtg_guard_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .ack_o(ack_o), .pins_o(pins_o),
    .wstrobe_o(wstrobe_o), .fast_exit_o(fast_exit_o));
  dtg_mem_model #(.WL(2), .BL(4), .AL(0)) dtg_mem_model_inst (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .pins_i(pins_o), .wstrobe_i(wstrobe_o), .err_count_o(err_count));

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // whole run is well under a thousand cycles
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic cmp_bits(input string what, input logic [19:0] exp, input logic [19:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_count(input string what, input int exp, input int got);
    compares++;
    if (got != exp) begin
      bad_count++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // holds the request until taken, so gap is measured ack to ack
  task automatic issue(input dtg_pkg::dtg_op_type op, input logic [1:0] ba,
      input logic [12:0] a, output logic [3:0] seen, output int gap);
    int n;
    n = 0;
    req_i = '{op: op, ba: ba, addr: a};
    req_valid_i = 1'b1;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (ack_o !== 1'b1 && n < 400);
    seen = {pins_o.cke, pins_o.ras_n, pins_o.cas_n, pins_o.we_n};
    gap = cyc - last_ack;
    last_ack = cyc;
    req_valid_i = 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  initial begin
    logic [3:0] seen;
    int gap;
    int acks;
    rows = '{
      '{dtg_pkg::DTG_MRS, 2'h0, 13'h0000, 4'h8, 1'b1, 8'h00},
      '{dtg_pkg::DTG_ACT, 2'h0, 13'h0000, 4'hb, 1'b1, 8'h02},
      '{dtg_pkg::DTG_ACT, 2'h1, 13'h0000, 4'hb, 1'b1, 8'h02},
      '{dtg_pkg::DTG_ACT, 2'h2, 13'h0000, 4'hb, 1'b1, 8'h02},
      '{dtg_pkg::DTG_ACT, 2'h3, 13'h0000, 4'hb, 1'b1, 8'h02},
      '{dtg_pkg::DTG_WR, 2'h0, 13'h0000, 4'hc, 1'b1, 8'h02},
      '{dtg_pkg::DTG_RD, 2'h0, 13'h0000, 4'hd, 1'b1, 8'h05},
      '{dtg_pkg::DTG_RD, 2'h1, 13'h0000, 4'hd, 1'b1, 8'h02},
      '{dtg_pkg::DTG_PRE, 2'h1, 13'h0000, 4'ha, 1'b1, 8'h02},
      '{dtg_pkg::DTG_WR, 2'h2, 13'h0000, 4'hc, 1'b1, 8'h02},
      '{dtg_pkg::DTG_PRE, 2'h2, 13'h0000, 4'ha, 1'b1, 8'h05},
      '{dtg_pkg::DTG_WR, 2'h3, 13'h0400, 4'hc, 1'b1, 8'h02},
      '{dtg_pkg::DTG_ACT, 2'h3, 13'h0000, 4'hb, 1'b1, 8'h06},
      '{dtg_pkg::DTG_PRE, 2'h0, 13'h0400, 4'ha, 1'b1, 8'h02},
      '{dtg_pkg::DTG_PDE, 2'h0, 13'h0000, 4'h7, 1'b1, 8'h00},
      '{dtg_pkg::DTG_PDX, 2'h0, 13'h0000, 4'hf, 1'b1, 8'h00},
      '{dtg_pkg::DTG_ACT, 2'h0, 13'h0000, 4'hb, 1'b1, 8'h02},
      '{dtg_pkg::DTG_PDE, 2'h0, 13'h0000, 4'h7, 1'b1, 8'h00},
      '{dtg_pkg::DTG_PDX, 2'h0, 13'h0000, 4'hf, 1'b1, 8'h00},
      '{dtg_pkg::DTG_RD, 2'h0, 13'h0000, 4'hd, 1'b1, 8'h02},
      '{dtg_pkg::DTG_PRE, 2'h0, 13'h0000, 4'ha, 1'b1, 8'h02},
      '{dtg_pkg::DTG_MRS, 2'h0, 13'h1000, 4'h8, 1'b0, 8'h00},
      '{dtg_pkg::DTG_ACT, 2'h0, 13'h0000, 4'hb, 1'b0, 8'h02},
      '{dtg_pkg::DTG_PDE, 2'h0, 13'h0000, 4'h7, 1'b0, 8'h00},
      '{dtg_pkg::DTG_PDX, 2'h0, 13'h0000, 4'hf, 1'b0, 8'h00},
      '{dtg_pkg::DTG_RD, 2'h0, 13'h0000, 4'hd, 1'b0, 8'h06},
      '{dtg_pkg::DTG_PRE, 2'h0, 13'h0000, 4'ha, 1'b0, 8'h02},
      '{dtg_pkg::DTG_SRE, 2'h0, 13'h0000, 4'h1, 1'b0, 8'h00},
      '{dtg_pkg::DTG_SRX, 2'h0, 13'h0000, 4'hf, 1'b0, 8'h00},
      '{dtg_pkg::DTG_ACT, 2'h0, 13'h0000, 4'hb, 1'b0, 8'h05},
      '{dtg_pkg::DTG_RD, 2'h0, 13'h0000, 4'hd, 1'b0, 8'hc3},
      '{dtg_pkg::DTG_PRE, 2'h0, 13'h0000, 4'ha, 1'b0, 8'h02}};
    repeat (6) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    foreach (rows[i]) begin
      issue(rows[i].op, rows[i].ba, rows[i].a, seen, gap);
      cmp_bits("command pins", 20'(rows[i].exp), 20'(seen));
      cmp_bits("fast exit", 20'(rows[i].fx), 20'(fast_exit_o));
      if (rows[i].gap != 8'h00) cmp_count("command gap", int'(rows[i].gap), gap);
    end
    $display("table test done");
    issue(dtg_pkg::DTG_REF, 2'h0, 13'h0000, seen, gap);
    cmp_bits("refresh pins", 20'h00009, 20'(seen));
    issue(dtg_pkg::DTG_MRS, 2'h0, 13'h0000, seen, gap);
    cmp_count("refresh gap", 4, gap);
    // requests made while powered down must wait for the exit
    issue(dtg_pkg::DTG_PDE, 2'h0, 13'h0000, seen, gap);
    acks = 0;
    req_i = '{op: dtg_pkg::DTG_ACT, ba: 2'h1, addr: 13'h0000};
    req_valid_i = 1'b1;
    repeat (20) begin
      @(posedge clk_i);
      #1;
      if (ack_o !== 1'b0) acks++;
    end
    req_valid_i = 1'b0;
    @(posedge clk_i);
    #1;
    cmp_count("acks in power-down", 0, acks);
    issue(dtg_pkg::DTG_PDX, 2'h0, 13'h0000, seen, gap);
    issue(dtg_pkg::DTG_ACT, 2'h1, 13'h0000, seen, gap);
    cmp_count("exit to activate gap", 2, gap);
    $display("power-down test done");
    issue(dtg_pkg::DTG_WR, 2'h1, 13'h0000, seen, gap);
    // second reset mid-write must clear the bank table and the strobe
    sys_rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    cmp_bits("pins in reset", 20'hf8000, pins_o);
    cmp_bits("ack and strobe in reset", 20'h00000, 20'({ack_o, wstrobe_o}));
    cmp_bits("fast exit in reset", 20'h00000, 20'(fast_exit_o));
    sys_rst_i = 1'b0;
    issue(dtg_pkg::DTG_ACT, 2'h1, 13'h0000, seen, gap);
    cmp_bits("activate after reset", 20'h0000b, 20'(seen));
    issue(dtg_pkg::DTG_WR, 2'h1, 13'h0000, seen, gap);
    @(posedge clk_i);
    #1;
    cmp_bits("strobe first beat", 20'h00001, 20'(wstrobe_o));
    @(posedge clk_i);
    #1;
    cmp_bits("strobe second beat", 20'h00001, 20'(wstrobe_o));
    @(posedge clk_i);
    #1;
    cmp_bits("strobe released", 20'h00000, 20'(wstrobe_o));
    cmp_bits("device timing faults", 20'h00000, 20'(err_count));
    $display("reset test done");
    report_and_stop();
  end
endmodule
